// ==== core/mms_cfg.svh ====
// Constants of the measurement mode sequencer: register codes, reset values
// and timing figures. Included by the package and the core.
`ifndef MMS_CFG_SVH
`define MMS_CFG_SVH

// ********************************************************************
// Mode codes of the mode control register
// ********************************************************************
`define MMS_MODE_W 3
`define MMS_MODE_POWERDOWN 3'h0
`define MMS_MODE_CONTINUOUS 3'h2
`define MMS_MODE_RESET 3'h0

// ********************************************************************
// Field positions
// ********************************************************************
`define MMS_SOFTRST_BIT 0
`define MMS_STAT_BUSY_BIT 7
`define MMS_STAT_SEL_BIT 0

// ********************************************************************
// Timing
// ********************************************************************
`define MMS_CLK_MHZ 250
`define MMS_SETUP_US 1000
`define MMS_MEAS_MS 300
`define MMS_IDLE_MS 1700
`define MMS_SOFTRST_CYC 16

`endif

// ==== core/mms_pkg.sv ====
// Types shared by the measurement mode sequencer.
// Assumes mms_cfg.svh is on the include path.
`include "mms_cfg.svh"

package mms_pkg;
    typedef enum logic [2:0]
    {
        MMS_OFF,
        MMS_SETUP,
        MMS_MEASURE,
        MMS_IDLE
    } mms_state_e;
    typedef logic [`MMS_MODE_W-1:0] mms_mode_t;
endpackage

// ==== core/mms_core.sv ====
// Control core of a gas-concentration sensor: interface select, resets and
// the continuous measurement loop with busy flag and result publication.
// Assumes a host interface block that decodes register writes into strobes.
//
// Behaviour
// - Select-pin low chooses two-wire bus, high chooses serial interface.
// - Select pin is pulled up; floating pin selects the serial interface.
// - Power-on reset fully resets all logic.
// - Host writing one to soft reset bit resets the device.
// - Soft reset bit clears itself when the reset completes.
// - Host writes mode register; device enters power-down or continuous mode.
// - Power-down stops master clock and all analog circuitry.
// - Continuous entry powers analog, waits setup, then busy bit and pin high.
// - First measurement ends after 0.3 s; busy bit and pin go low.
// - After each measurement analog stops and block idles at low power.
// - After 1.7 s idle analog restarts and a new busy measurement begins.
// - Measurement end publishes the new concentration result.
// - Measure-idle loop repeats until a non-continuous mode is written to the mode register.
`timescale 1ns/1ps
`include "mms_cfg.svh"

module mms_core
    import mms_pkg::*;
#(
    parameter int SETUP_CYC = `MMS_SETUP_US * `MMS_CLK_MHZ,
    parameter int MEAS_CYC = `MMS_MEAS_MS * 1000 * `MMS_CLK_MHZ,
    parameter int IDLE_CYC = `MMS_IDLE_MS * 1000 * `MMS_CLK_MHZ,
    parameter int RESULT_W = 15
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic selPinIn,
    input wire logic selPinDriven,
    input wire logic modeWrite,
    input wire logic [`MMS_MODE_W-1:0] modeWdata,
    input wire logic softRstWrite,
    input wire logic softRstWdata,
    input wire logic [RESULT_W-1:0] adcResult,
    output logic useTwoWire,
    output logic softRstBit,
    output mms_mode_t modeReg,
    output logic [7:0] statusReg,
    output logic busyPin,
    output logic masterClkEn,
    output logic analogPowerEn,
    output logic hostIfEn,
    output logic [7:0] concLowByte,
    output logic [7:0] concHighByte,
    output logic resultReady
);

    // ********************************************************************
    // Reset sources
    // ********************************************************************
    logic [4:0] softCnt_reg;
    logic softRst_reg;
    logic coreRst;

    // Soft reset clears the sequencer but leaves the soft reset bit itself
    // alive long enough to report completion.
    assign coreRst = !nrst || softRst_reg;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            softRst_reg <= 1'b0;
            softCnt_reg <= 5'h0;
        end
        else if (softRstWrite && softRstWdata && !softRst_reg)
        begin
            softRst_reg <= 1'b1;
            softCnt_reg <= 5'(`MMS_SOFTRST_CYC);
        end
        else if (softRst_reg)
        begin
            if (softCnt_reg == 5'h1)
                softRst_reg <= 1'b0;
            softCnt_reg <= softCnt_reg - 5'h1;
        end
    end
    assign softRstBit = softRst_reg;

    // ********************************************************************
    // Interface select strap
    // ********************************************************************
    logic selLevel;
    assign selLevel = selPinDriven ? selPinIn : 1'b1;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            useTwoWire <= 1'b0;
        else
            useTwoWire <= !selLevel;
    end

    // ********************************************************************
    // Mode register
    // ********************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (coreRst)
            modeReg <= `MMS_MODE_RESET;
        else if (modeWrite)
            modeReg <= modeWdata;
    end

    // ********************************************************************
    // Measurement sequencer
    // ********************************************************************
    mms_state_e state_reg;
    mms_state_e state_next;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic contMode;
    logic cntDone;

    function automatic logic [31:0] load(input int cyc);
        load = (cyc < 1) ? 32'h0 : 32'(cyc - 1);
    endfunction

    assign contMode = (modeReg == `MMS_MODE_CONTINUOUS);
    assign cntDone = (cnt_reg == 32'h0);

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cntDone ? 32'h0 : cnt_reg - 32'h1;
        case (state_reg)
            MMS_OFF:
                if (contMode)
                begin
                    state_next = MMS_SETUP;
                    cnt_next = load(SETUP_CYC);
                end
            MMS_SETUP:
                if (cntDone)
                begin
                    state_next = MMS_MEASURE;
                    cnt_next = load(MEAS_CYC);
                end
            MMS_MEASURE:
                if (cntDone)
                begin
                    state_next = MMS_IDLE;
                    cnt_next = load(IDLE_CYC);
                end
            MMS_IDLE:
                if (cntDone)
                begin
                    state_next = MMS_MEASURE;
                    cnt_next = load(MEAS_CYC);
                end
            default:
                state_next = MMS_OFF;
        endcase
        // A mode change abandons any measurement in flight.
        if (!contMode)
        begin
            state_next = MMS_OFF;
            cnt_next = 32'h0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (coreRst)
            state_reg <= MMS_OFF;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge sys_clk)
    begin
        if (coreRst)
            cnt_reg <= 32'h0;
        else
            cnt_reg <= cnt_next;
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    logic measEnd;
    assign measEnd = (state_reg == MMS_MEASURE) && cntDone && contMode;

    always_ff @(posedge sys_clk)
    begin
        if (coreRst)
        begin
            busyPin <= 1'b0;
            masterClkEn <= 1'b0;
            analogPowerEn <= 1'b0;
        end
        else
        begin
            busyPin <= (state_next == MMS_MEASURE);
            masterClkEn <= (state_next != MMS_OFF);
            analogPowerEn <= (state_next == MMS_SETUP)
                || (state_next == MMS_MEASURE);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (coreRst)
        begin
            concLowByte <= 8'h00;
            concHighByte <= 8'h00;
            resultReady <= 1'b0;
        end
        else
        begin
            resultReady <= measEnd;
            if (measEnd)
            begin
                concLowByte <= adcResult[7:0];
                concHighByte <= {1'b0, adcResult[RESULT_W-1:8]};
            end
        end
    end

    // The host interface keeps running from its own clock even while the
    // master clock is stopped, so the mode can always be rewritten.
    assign hostIfEn = 1'b1;

    always_comb
    begin
        statusReg = 8'h00;
        statusReg[`MMS_STAT_BUSY_BIT] = busyPin;
        // Taken from the registered strap so the byte comes from flip-flops.
        statusReg[`MMS_STAT_SEL_BIT] = !useTwoWire;
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    property p_busy_rise;
        @(posedge sys_clk) disable iff (coreRst)
        (state_reg == MMS_SETUP && cntDone && contMode) |=> busyPin;
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("busy did not rise after setup");

    property p_busy_fall;
        @(posedge sys_clk) disable iff (coreRst)
        measEnd |=> !busyPin && resultReady;
    endproperty
    a_busy_fall: assert property (p_busy_fall)
        else $error("busy did not fall at measurement end");

    property p_idle_analog;
        @(posedge sys_clk) disable iff (coreRst)
        (state_reg == MMS_IDLE) |-> !analogPowerEn && !busyPin;
    endproperty
    a_idle_analog: assert property (p_idle_analog)
        else $error("analog powered while idle");

    property p_restart;
        @(posedge sys_clk) disable iff (coreRst)
        (state_reg == MMS_IDLE && cntDone && contMode) |=> busyPin
            && analogPowerEn;
    endproperty
    a_restart: assert property (p_restart)
        else $error("measurement did not restart after idle");

    property p_result;
        @(posedge sys_clk) disable iff (coreRst)
        measEnd |=> {concHighByte[6:0], concLowByte} == $past(adcResult);
    endproperty
    a_result: assert property (p_result)
        else $error("result not published");

    property p_powerdown;
        @(posedge sys_clk) disable iff (coreRst)
        (modeReg == `MMS_MODE_POWERDOWN) |=> !masterClkEn && !analogPowerEn;
    endproperty
    a_powerdown: assert property (p_powerdown)
        else $error("clock running in power-down");

    property p_mode_write;
        @(posedge sys_clk) disable iff (coreRst)
        modeWrite |=> modeReg == $past(modeWdata);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode write lost");

    property p_soft_clear;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(softRst_reg) |-> ##15 softRst_reg ##1 !softRst_reg;
    endproperty
    a_soft_clear: assert property (p_soft_clear)
        else $error("soft reset bit did not self-clear");

    property p_select;
        @(posedge sys_clk) disable iff (!nrst)
        (!selPinDriven) |=> !useTwoWire;
    endproperty
    a_select: assert property (p_select)
        else $error("floating select pin did not pick serial");

endmodule

// ==== bench/mms_host_model.sv ====
// Host controller model: writes mode and soft reset, reads the result.
// Assumes inputs change at the falling edge of sys_clk.
`timescale 1ns/1ps

// ****************************************
// Host side of the register writes
// ****************************************
module mms_host_model
(
    input wire logic sys_clk,
    input wire logic busyPin,
    input wire logic [7:0] concLowByte,
    input wire logic [7:0] concHighByte,
    output logic modeWrite,
    output logic [2:0] modeWdata,
    output logic softRstWrite,
    output logic softRstWdata,
    output logic [14:0] hostResult
);
    logic busyPrev;

    initial
    begin
        modeWrite = 1'b0;
        modeWdata = 3'h0;
        softRstWrite = 1'b0;
        softRstWdata = 1'b0;
        hostResult = 15'h0;
        busyPrev = 1'b0;
    end

    // One-cycle write pulse, data held with the strobe.
    // The two-wire framing of start, addresses, acknowledges and stop is
    // taken as already folded into this strobe by the interface block.
    task automatic writeMode(input logic [2:0] v);
        @(negedge sys_clk);
        modeWrite = 1'b1;
        modeWdata = v;
        @(negedge sys_clk);
        modeWrite = 1'b0;
        modeWdata = ~v;
    endtask

    task automatic softReset(input logic v);
        @(negedge sys_clk);
        softRstWrite = 1'b1;
        softRstWdata = v;
        @(negedge sys_clk);
        softRstWrite = 1'b0;
        softRstWdata = 1'b0;
    endtask

    // The result is fetched only once busy has fallen.
    always @(posedge sys_clk)
    begin
        if (busyPrev && !busyPin)
        begin
            hostResult <= {concHighByte[6:0], concLowByte};
        end
        busyPrev <= busyPin;
    end
endmodule

// ==== bench/measurement_mode_sequencer_tb_top.sv ====
// Self-checking bench of the mode sequencer with shortened timing.
// Assumes mms_pkg, mms_core and the host model are compiled first.
`timescale 1ns/1ps
`include "mms_cfg.svh"
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; \
 $display("Error t=%0t got %h exp %h", $time, a, b); end end

// ****************************************
// Bench top
// ****************************************
module measurement_mode_sequencer_tb_top;
    import mms_pkg::*;
    localparam int SETUP = 5;
    localparam int MEAS = 10;
    localparam int IDLE = 20;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic selPinIn = 1'b0;
    logic selPinDriven = 1'b0;
    logic [14:0] adcResult = 15'h0;
    logic [15:0] lfsrReg = 16'h003c;
    logic modeWrite, softRstWrite, softRstWdata, useTwoWire, softRstBit;
    logic busyPin, masterClkEn, analogPowerEn, hostIfEn, resultReady;
    logic [2:0] modeWdata;
    mms_mode_t modeReg;
    logic [7:0] statusReg, concLowByte, concHighByte;
    logic [14:0] hostResult;
    int errCount = 0;
    int samplesChecked = 0;
    int n;
    logic expSel;
    logic [14:0] expQ[$];
    logic [14:0] expVal;

    always #2 sys_clk = ~sys_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Front end output is only held while the analog part is powered.
    always @(negedge sys_clk)
    begin
        if (!analogPowerEn)
        begin
            lfsrReg = lfsr(lfsrReg);
            adcResult <= lfsrReg[14:0];
        end
    end

    mms_core #(.SETUP_CYC(SETUP), .MEAS_CYC(MEAS), .IDLE_CYC(IDLE)) u_mms_core
    (
        .sys_clk(sys_clk), .nrst(nrst), .selPinIn(selPinIn),
        .selPinDriven(selPinDriven), .modeWrite(modeWrite),
        .modeWdata(modeWdata), .softRstWrite(softRstWrite),
        .softRstWdata(softRstWdata), .adcResult(adcResult),
        .useTwoWire(useTwoWire), .softRstBit(softRstBit), .modeReg(modeReg),
        .statusReg(statusReg), .busyPin(busyPin), .masterClkEn(masterClkEn),
        .analogPowerEn(analogPowerEn), .hostIfEn(hostIfEn),
        .concLowByte(concLowByte), .concHighByte(concHighByte),
        .resultReady(resultReady)
    );

    mms_host_model u_mms_host_model
    (
        .sys_clk(sys_clk), .busyPin(busyPin), .concLowByte(concLowByte),
        .concHighByte(concHighByte), .modeWrite(modeWrite),
        .modeWdata(modeWdata), .softRstWrite(softRstWrite),
        .softRstWdata(softRstWdata), .hostResult(hostResult)
    );

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Counts cycles until busy reaches the level, bounded against a hang.
    task automatic waitBusy(input logic lvl, output int cyc);
        cyc = 0;
        while (busyPin !== lvl && cyc < 200)
        begin
            @(negedge sys_clk);
            cyc++;
        end
    endtask

    initial
    begin
        #40000;
        errCount++;
        giveVerdict();
    end

    initial
    begin
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        `CHK(modeReg, 3'h0)
        `CHK({busyPin, masterClkEn, analogPowerEn, hostIfEn}, 4'h1)
        $display("reset test done");
        for (int i = 0; i < 4; i++)
        begin
            selPinDriven = i[1];
            selPinIn = i[0];
            repeat (2) @(negedge sys_clk);
            expSel = i[1] ? i[0] : 1'b1;
            `CHK(useTwoWire, ~expSel)
            `CHK(statusReg[0], expSel)
        end
        $display("select test done");
        u_mms_host_model.writeMode(3'h2);
        `CHK(modeReg, 3'h2)
        @(negedge sys_clk);
        `CHK({masterClkEn, analogPowerEn}, 2'h3)
        for (int k = 0; k < 2; k++)
        begin
            waitBusy(1'b1, n);
            `CHK(statusReg, 8'h81)
            `CHK(analogPowerEn, 1'b1)
            expQ.push_back(adcResult);
            waitBusy(1'b0, n);
            `CHK(n, MEAS)
            `CHK({statusReg[7], analogPowerEn, resultReady}, 3'h1)
            `CHK(concHighByte[7], 1'b0)
            @(negedge sys_clk);
            `CHK(resultReady, 1'b0)
            expVal = expQ.pop_front();
            `CHK(hostResult, expVal)
            waitBusy(1'b1, n);
            `CHK(n + 1, IDLE)
        end
        $display("continuous test done");
        u_mms_host_model.writeMode(3'h0);
        @(negedge sys_clk);
        `CHK({masterClkEn, analogPowerEn, busyPin}, 3'h0)
        `CHK(hostIfEn, 1'b1)
        u_mms_host_model.writeMode(3'h5);
        @(negedge sys_clk);
        `CHK({masterClkEn, analogPowerEn}, 2'h0)
        u_mms_host_model.writeMode(3'h2);
        @(negedge sys_clk);
        `CHK(masterClkEn, 1'b1)
        $display("power-down test done");
        u_mms_host_model.softReset(1'b0);
        `CHK({softRstBit, modeReg}, 4'h2)
        u_mms_host_model.softReset(1'b1);
        `CHK(softRstBit, 1'b1)
        n = 0;
        while (softRstBit === 1'b1 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(n, `MMS_SOFTRST_CYC)
        `CHK({modeReg, busyPin, analogPowerEn}, 5'h0)
        $display("soft reset test done");
        giveVerdict();
    end
endmodule
